// *** hw/srof_pkg.sv ***
// Purpose: Shared constants and carrier types for the synthesizer ratio and offset registers
// Assumes: AXI4-Lite slave with 32-bit data, one aligned word per register
// Notes: Offsets 0x5c and 0x73 are register indices; byte address is four times the index
package srof_pkg;
  // Register indices as printed, byte address = index * 4
  localparam logic [7:0] IDX_RATIO = 8'h5c;
  localparam logic [7:0] IDX_TRIM = 8'h73;
  localparam logic [7:0] IDX_GATE = 8'h80;
  localparam logic [11:0] ADDR_RATIO = {2'h0, IDX_RATIO, 2'h0};
  localparam logic [11:0] ADDR_TRIM = {2'h0, IDX_TRIM, 2'h0};
  localparam logic [11:0] ADDR_GATE = {2'h0, IDX_GATE, 2'h0};
  // Field positions
  localparam int NUM_LSB = 16;
  localparam int DEN_LSB = 0;
  localparam int GATE_BITS = 2;
  localparam int SYNTH_COUNT = 4;
  localparam int FIXED_FACTOR = 16;
  localparam int TRIM_FRAC_BITS = 32;
  // Reset values
  localparam logic [31:0] RATIO_RESET = 32'h00010001;
  localparam logic [31:0] TRIM_RESET = 32'h046aaaab;
  localparam logic [7:0] GATE_RESET = 8'h03;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Ratio register layout
  typedef struct packed {
    logic [15:0] ratio_numerator;
    logic [15:0] ratio_denominator;
  } srof_ratio_t;
endpackage : srof_pkg

// *** hw/srof_regs.sv ***
// Purpose: Ratio, output gate and central frequency trim registers with frequency math
// Assumes: base_frequency and base_multiplier arrive from other register blocks
// Notes: Answers a write one cycle after both channels are taken, a read one cycle after the address
// Overview of operation
// - Ratio register: numerator in bits 31:16, denominator in bits 15:0, both unsigned.
// - Synth frequency equals base times multiplier times sixteen times numerator over denominator.
// - Synth 0 output driven only while gate bit 0 set; synth 1 while bit 1.
// - Trim register is two's complement, one step scales nominal by two to minus 32.
// - One trim value applies to the centre frequency of all four synthesizers.
// - NCO output is initial frequency times one plus trim over two to the 32.
`timescale 1ns/1ps
module srof_regs (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Frequency inputs from neighbouring registers
  input wire logic [15:0] base_frequency,
  input wire logic [15:0] base_multiplier,
  // Synthesizer clocks to gate
  input wire logic synth0_clk_in,
  input wire logic synth1_clk_in,
  // Results
  output logic synth0_out,
  output logic synth1_out,
  output logic [63:0] synth_freq_hz,
  output logic [95:0] nco_freq_scaled,
  output logic [31:0] trim_to_synth [srof_pkg::SYNTH_COUNT]
);
  // Register contents
  srof_pkg::srof_ratio_t synth1_ratio;
  logic [31:0] center_freq_trim;
  logic [7:0] synth_output_gate;
  // Write channel staging
  logic aw_held, w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  // Next values and address decode
  logic do_write;
  logic [31:0] next_ratio, next_trim, rd_word;
  logic [7:0] next_gate;
  logic rd_hit, wr_hit;

  // Take address and data in either order, one write at a time
  // A held channel refuses the next beat until the response is taken
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Write channel capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Byte-lane merge of the stored word with the write data
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    // Lanes with a clear strobe keep their stored byte
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  always_comb begin
    next_ratio = merge(synth1_ratio, w_data, w_strb);
    next_trim = merge(center_freq_trim, w_data, w_strb);
    // Gate takes lane 0 only; the six reserved bits stay zero
    next_gate = synth_output_gate;
    if (w_strb[0]) begin
      next_gate = {6'h00, w_data[srof_pkg::GATE_BITS-1:0]};
    end
    // Decode of the staged write address
    wr_hit = (aw_addr == srof_pkg::ADDR_RATIO) || (aw_addr == srof_pkg::ADDR_TRIM)
      || (aw_addr == srof_pkg::ADDR_GATE);
  end

  // Register storage
  // Unmapped addresses leave every register untouched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      synth1_ratio <= srof_pkg::RATIO_RESET;
      center_freq_trim <= srof_pkg::TRIM_RESET;
      synth_output_gate <= srof_pkg::GATE_RESET;
    end else if (do_write) begin
      if (aw_addr == srof_pkg::ADDR_RATIO) begin
        synth1_ratio <= next_ratio;
      end
      if (aw_addr == srof_pkg::ADDR_TRIM) begin
        center_freq_trim <= next_trim;
      end
      if (aw_addr == srof_pkg::ADDR_GATE) begin
        synth_output_gate <= next_gate;
      end
    end
  end

  // Write response; unmapped addresses get SLVERR
  // Response stands until bready; no new write is taken meanwhile
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= srof_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? srof_pkg::RESP_OKAY : srof_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read decode
  // Unmapped reads return zero with an error response
  always_comb begin
    rd_hit = 1'b1;
    rd_word = 32'h00000000;
    case (s_axi_araddr)
      srof_pkg::ADDR_RATIO: rd_word = synth1_ratio;
      srof_pkg::ADDR_TRIM: rd_word = center_freq_trim;
      srof_pkg::ADDR_GATE: rd_word = {30'h0, synth_output_gate[1:0]};
      default: rd_hit = 1'b0;
    endcase
  end

  // Read data, registered
  // Data and response stand until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= srof_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? srof_pkg::RESP_OKAY : srof_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Output gating; glitches possible when the gate changes mid-cycle of the synth clock
  // Reset value opens both outputs
  assign synth0_out = synth0_clk_in & synth_output_gate[0];
  assign synth1_out = synth1_clk_in & synth_output_gate[1];

  // One trim value fans out to every synthesizer
  always_comb begin
    for (int i = 0; i < srof_pkg::SYNTH_COUNT; i++) begin
      trim_to_synth[i] = center_freq_trim;
    end
  end

  // Frequency math, pipelined; zero denominator yields zero rather than a divide fault
  // Widest product is 52 bits, so 64 bits never overflow
  logic [63:0] prod;
  logic [63:0] next_freq;
  logic [95:0] next_nco;
  always_comb begin
    prod = 64'(base_frequency) * 64'(base_multiplier) * 64'(srof_pkg::FIXED_FACTOR)
      * 64'(synth1_ratio.ratio_numerator);
    next_freq = (synth1_ratio.ratio_denominator == 16'h0000) ? 64'h0
      : prod / 64'(synth1_ratio.ratio_denominator);
    // Initial frequency scaled by 2^32 + trim, still in 2^-32 units
    // Signed product keeps a negative trim below nominal
    next_nco = 96'($signed({32'h00000000, next_freq}) * $signed({{32{center_freq_trim[31]}},
      center_freq_trim}) + $signed({next_freq, 32'h00000000}));
  end

  // Both results share one cycle of latency
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      synth_freq_hz <= 64'h0;
      nco_freq_scaled <= 96'h0;
    end else begin
      synth_freq_hz <= next_freq;
      nco_freq_scaled <= next_nco;
    end
  end
endmodule : srof_regs

// *** verification/srof_regs_monitor.sv ***
// Purpose: Port checker for srof_regs
// Assumes: One clock, sync active low reset
// Notes: Gate bits are internal, so gating is checked one way only
`timescale 1ns/1ps
module srof_regs_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Synth side
  input wire logic [15:0] base_frequency,
  input wire logic synth0_clk_in,
  input wire logic synth1_clk_in,
  input wire logic synth0_out,
  input wire logic synth1_out,
  input wire logic [63:0] synth_freq_hz,
  input wire logic [95:0] nco_freq_scaled,
  input wire logic [31:0] trim_to_synth [srof_pkg::SYNTH_COUNT]
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // An output may only pass its own clock
  a_gate_synth0: assert property (synth0_out |-> synth0_clk_in)
    else $error("synth0 out without clock");
  a_gate_synth1: assert property (synth1_out |-> synth1_clk_in)
    else $error("synth1 out without clock");
  // One trim value reaches every synth
  a_trim_fanout: assert property (trim_to_synth[0] == trim_to_synth[1] && trim_to_synth[2] == trim_to_synth[3]
    && trim_to_synth[1] == trim_to_synth[2]) else $error("trim copies differ");
  // A zero base gives zero frequency a cycle later
  a_freq_zero_base: assert property (base_frequency == 16'h0 |=> synth_freq_hz == 64'h0)
    else $error("frequency not zero for zero base");
  // Signed trim scales frequency, same latency for both
  a_nco_scale_trim: assert property (
    nco_freq_scaled == 96'(synth_freq_hz) * (96'h1_0000_0000 + 96'($signed($past(trim_to_synth[0])))))
    else $error("nco value wrong");
  // Base held at zero over two edges
  sequence s_base_held_zero;
    base_frequency == 16'h0 ##1 base_frequency == 16'h0;
  endsequence
  // Zero base empties the nco product once the frequency stage has passed
  a_nco_zero_base: assert property (s_base_held_zero |=> nco_freq_scaled == 96'h0)
    else $error("nco not zero for zero base");
endmodule : srof_regs_monitor
bind srof_regs srof_regs_monitor srof_regs_monitor_inst (.aclk, .aresetn, .base_frequency, .synth0_clk_in,
  .synth1_clk_in, .synth0_out, .synth1_out, .synth_freq_hz, .nco_freq_scaled, .trim_to_synth);

// *** verification/srof_regs_tb.sv ***
// Purpose: Self-checking bench for srof_regs
// Assumes: 250 MHz clock, one bus task for both directions
// Notes: Row table writes and reads back; reset and frequency checked after
`timescale 1ns/1ps
module srof_regs_tb;
  typedef struct packed {logic [11:0] addr; logic [31:0] wdata, rexp; logic [1:0] resp; logic [31:0] rst;} srof_row_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, synth0_clk_in, synth1_clk_in, synth0_out, synth1_out;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [15:0] base_frequency, base_multiplier;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [63:0] synth_freq_hz;
  logic [95:0] nco_freq_scaled;
  logic [31:0] trim_to_synth [srof_pkg::SYNTH_COUNT];
  int n_fail = 0, num_checks = 0;
  srof_row_t rows [5] = '{
    '{srof_pkg::ADDR_RATIO, 32'h00ff00ed, 32'h00ff00ed, srof_pkg::RESP_OKAY, srof_pkg::RATIO_RESET},
    '{srof_pkg::ADDR_TRIM, 32'hfafafafb, 32'hfafafafb, srof_pkg::RESP_OKAY, srof_pkg::TRIM_RESET},
    '{srof_pkg::ADDR_GATE, 32'hffffffff, 32'h3, srof_pkg::RESP_OKAY, 32'h3},
    '{srof_pkg::ADDR_GATE, 32'h1, 32'h1, srof_pkg::RESP_OKAY, 32'h3},
    '{12'h004, 32'h12345678, 32'h0, srof_pkg::RESP_SLVERR, 32'h0}};
  srof_regs srof_regs_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .base_frequency,
    .base_multiplier, .synth0_clk_in, .synth1_clk_in, .synth0_out, .synth1_out, .synth_freq_hz,
    .nco_freq_scaled, .trim_to_synth);
  // Clock and watchdog, limit well above the run length
  initial begin aclk = 1'b0; forever #2 aclk = ~aclk; end
  initial begin #4000; n_fail++; end_of_test(); end
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One transfer; each valid drops only at the edge that takes it
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic [1:0] resp);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1);
    {rd, resp} = {s_axi_rdata, w ? s_axi_bresp : s_axi_rresp};
    {s_axi_bready, s_axi_rready} <= 2'b00;
  endtask : bus
  task automatic end_of_test();
    $display("checks=%0d failures=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {24'h0, 32'h0, 4'hf};
    {base_frequency, base_multiplier} = {16'h9c40, 16'h0798};
    {synth0_clk_in, synth1_clk_in, aresetn} = 3'b110;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b1, rows[i].addr, rows[i].wdata, q, r);
      chk(64'(r), 64'(rows[i].resp));
      bus(1'b0, rows[i].addr, 32'h0, q, r);
      chk(64'(q), 64'(rows[i].rexp));
      chk(64'(r), 64'(rows[i].resp));
    end
    chk(synth_freq_hz, 64'h9c40 * 64'h0798 * 64'h10 * 64'hff / 64'hed);
    // Fast reference trim from the rows pulls the output below nominal
    chk(nco_freq_scaled, 96'(64'h9c40 * 64'h0798 * 64'h10 * 64'hff / 64'hed) * 96'hfafafafb);
    chk(96'(trim_to_synth[3]), 96'hfafafafb);
    chk(64'({synth1_out, synth0_out}), 64'h1);
    // Stopped synth clocks leave both outputs low
    {synth0_clk_in, synth1_clk_in} <= 2'b00;
    @(posedge aclk);
    chk(64'({synth1_out, synth0_out}), 64'h0);
    {synth0_clk_in, synth1_clk_in} <= 2'b11;
    // Reset in mid-run restores every register
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b0, rows[i].addr, 32'h0, q, r);
      chk(64'(q), 64'(rows[i].rst));
    end
    chk(synth_freq_hz, 64'h9c40 * 64'h0798 * 64'h10);
    chk(64'({synth1_out, synth0_out}), 64'h3);
    // Slow reference: software programs a positive trim and the output rises
    bus(1'b1, srof_pkg::ADDR_TRIM, 32'h0539782a, q, r);
    bus(1'b0, srof_pkg::ADDR_TRIM, 32'h0, q, r);
    chk(64'(q), 64'h0539782a);
    chk(nco_freq_scaled, 96'(64'h9c40 * 64'h0798 * 64'h10) * 96'h1_0539_782a);
    chk(96'(trim_to_synth[0]), 96'h0539782a);
    // Lower lanes only: denominator becomes two, numerator kept
    s_axi_wstrb <= 4'h3;
    bus(1'b1, srof_pkg::ADDR_RATIO, 32'hffff0002, q, r);
    bus(1'b0, srof_pkg::ADDR_RATIO, 32'h0, q, r);
    chk(64'(q), 64'h00010002);
    chk(synth_freq_hz, 64'h9c40 * 64'h0798 * 64'h10 / 64'h2);
    s_axi_wstrb <= 4'hf;
    // Zero base over several edges empties both results
    base_frequency <= 16'h0;
    repeat (4) @(posedge aclk);
    chk(synth_freq_hz, 64'h0);
    chk(nco_freq_scaled, 96'h0);
    end_of_test();
  end
endmodule : srof_regs_tb
